// >>> hw/gpio_pin_irq_pkg.sv
// Constants, register layout and carrier types of the GPIO port block
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses
package gpio_pin_irq_pkg;
  // ==========================================================
  // Sizes
  localparam int PORT_W = 32;
  localparam int HALF_W = 8;
  localparam int N_CHAN = 6;
  localparam int N_FUNC = 5;
  localparam int SEL_W = 3;
  localparam int MUX_FW = 4;
  localparam int HSEL_W = 4;
  localparam int AW = 12;
  // ==========================================================
  // Address map: ports at 0x000 + p*0x80, channels at 0x400 + c*0x40
  localparam logic [1:0] REGION_PORT = 2'h0;
  localparam logic [1:0] REGION_CHAN = 2'h1;
  localparam logic [6:0] OFS_SET = 7'h04;
  localparam logic [6:0] OFS_CLR = 7'h08;
  localparam logic [6:0] OFS_DATA = 7'h00;
  localparam logic [6:0] OFS_DIR = 7'h0c;
  localparam logic [6:0] OFS_INEN = 7'h18;
  localparam logic [6:0] OFS_IMASK = 7'h24;
  localparam logic [6:0] OFS_SENS = 7'h30;
  localparam logic [6:0] OFS_BOTH = 7'h3c;
  localparam logic [6:0] OFS_INPUT = 7'h48;
  localparam logic [6:0] OFS_ISTAT = 7'h4c;
  localparam logic [6:0] OFS_MUX = 7'h50;
  localparam logic [6:0] OFS_MUX_LAST = 7'h5c;
  localparam logic [6:0] OFS_C_MASK = 7'h00;
  localparam logic [6:0] OFS_C_EDGE = 7'h0c;
  localparam logic [6:0] OFS_C_INV = 7'h18;
  localparam logic [6:0] OFS_C_ASSIGN = 7'h24;
  localparam logic [6:0] OFS_C_REQ = 7'h28;
  localparam logic [6:0] OFS_C_LATCH = 7'h2c;
  localparam logic [6:0] OFS_C_PSTATE = 7'h30;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ==========================================================
  // Carrier
  typedef struct packed {
    logic [PORT_W-1:0] mask;
    logic [PORT_W-1:0] edge_en;
    logic [PORT_W-1:0] inv;
  } chan_cfg_s;
endpackage

// >>> hw/pin_irq_channel.sv
// One pin-interrupt channel: polarity, edge or level latch, mask, request
// Assumes pins are already synchronised to i_clk
`timescale 1ns/100ps
`default_nettype none
module pin_irq_channel (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [gpio_pin_irq_pkg::PORT_W-1:0] i_pins,
  input wire gpio_pin_irq_pkg::chan_cfg_s i_cfg,
  input wire logic [gpio_pin_irq_pkg::PORT_W-1:0] i_clr,
  output logic [gpio_pin_irq_pkg::PORT_W-1:0] o_latch,
  output logic o_irq
);
  import gpio_pin_irq_pkg::*;
  logic [PORT_W-1:0] lvl;
  logic [PORT_W-1:0] hit;
  logic [PORT_W-1:0] prev_r;
  logic [PORT_W-1:0] latch_r;
  logic irq_r;

  assign lvl = i_pins ^ i_cfg.inv;
  assign hit = lvl & ~prev_r;
  assign o_latch = latch_r;
  assign o_irq = irq_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= lvl;
    end
  end

  // Edge bits: a new edge beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_r <= '0;
    end else begin
      latch_r <= (i_cfg.edge_en & ((latch_r & ~i_clr) | hit)) | (~i_cfg.edge_en & lvl);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(latch_r & i_cfg.mask);
    end
  end

  AST_EDGE_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_cfg.edge_en[0] && hit[0]) |=> latch_r[0])
    else $error("edge not captured");
  AST_EDGE_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_cfg.edge_en[0] && latch_r[0] && !i_clr[0] && $stable(i_cfg.edge_en)) |=> latch_r[0])
    else $error("edge latch lost without clear");
  AST_LEVEL_FOLLOW: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_cfg.edge_en[0] |=> latch_r[0] == $past(lvl[0]))
    else $error("level latch does not follow pin");
  AST_CH_IRQ_ON: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (latch_r[0] && i_cfg.mask[0]) |=> o_irq)
    else $error("unmasked latch gives no request");
  AST_CH_IRQ_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ((latch_r & i_cfg.mask) == '0) |=> !o_irq)
    else $error("request without unmasked latch");
endmodule // pin_irq_channel
`default_nettype wire

// >>> hw/gpio_pin_irq_port.sv
// GPIO ports with peripheral multiplexing and six pin-interrupt channels
// Assumes an AXI4-Lite master on i_clk and pads sampled asynchronously
`timescale 1ns/100ps
`default_nettype none

module gpio_pin_irq_port #(
  parameter int NPORT = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [gpio_pin_irq_pkg::AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [gpio_pin_irq_pkg::AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [NPORT*gpio_pin_irq_pkg::PORT_W-1:0] i_pad_in,
  output logic [NPORT*gpio_pin_irq_pkg::PORT_W-1:0] o_pad_out,
  output logic [NPORT*gpio_pin_irq_pkg::PORT_W-1:0] o_pad_oe_n,
  input wire logic [gpio_pin_irq_pkg::N_FUNC-1:0][NPORT*gpio_pin_irq_pkg::PORT_W-1:0] i_func_out,
  input wire logic [gpio_pin_irq_pkg::N_FUNC-1:0][NPORT*gpio_pin_irq_pkg::PORT_W-1:0] i_func_oe,
  output logic [NPORT*gpio_pin_irq_pkg::PORT_W-1:0] o_func_in,
  output logic o_irq,
  output logic [gpio_pin_irq_pkg::N_CHAN-1:0] o_pin_irq
);
  import gpio_pin_irq_pkg::*;
  localparam int NP = NPORT * PORT_W;
  localparam int NH = NP / HALF_W;
  localparam int CW = N_CHAN * PORT_W;

  logic aw_rdy_r;
  logic w_rdy_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [AW-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [31:0] wmask_r;
  logic wr_go;
  logic wr_hit;
  logic pwr;
  logic cwr;
  logic [6:0] wo;
  logic [6:0] wco;
  logic [2:0] wp;
  logic [3:0] wc;
  logic [31:0] wv;
  logic ar_rdy_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_v;
  logic ar_go;
  logic [6:0] ro;
  logic [6:0] rco;
  logic [2:0] rp;
  logic [3:0] rc;
  logic [NP-1:0] data_r, dir_r, inen_r, imask_r, sens_r, both_r;
  logic [NP-1:0] istat_r, rdclr;
  logic [NP*MUX_FW-1:0] mux_r;
  logic [NP-1:0] sync1_r, sync2_r, gprev_r;
  logic [NP-1:0] pad_out_r, pad_oe_n_r, func_in_r;
  logic irq_r;
  logic [CW-1:0] cmask_r, cedge_r, cinv_r, cassign_r, cclr;
  wire [NP-1:0] gval, gev, out_v, oe_v, rx_v;
  wire [CW-1:0] cpins, clatch;

  // ==========================================================
  // Helpers
  function automatic logic mapped(input logic [AW-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0 && a[AW-1:AW-2] == REGION_PORT) begin
      ok = (int'(a[9:7]) < NPORT) && (a[6:0] <= OFS_MUX_LAST);
    end else if (a[1:0] == 2'h0 && a[AW-1:AW-2] == REGION_CHAN) begin
      ok = (int'(a[9:6]) < N_CHAN) && ({1'b0, a[5:0]} <= OFS_C_PSTATE);
    end
    return ok;
  endfunction

  function automatic logic in3(input logic [6:0] o, input logic [6:0] b);
    return (o >= b) && (o <= 7'(b + OFS_CLR));
  endfunction

  // Base, set alias and clear alias of one control word
  function automatic logic [31:0] upd3(input logic [31:0] cur, input logic [6:0] o,
                                       input logic [6:0] b);
    logic [31:0] r;
    r = cur;
    if (o == b) begin
      r = (cur & ~wmask_r) | wv;
    end else if (o == 7'(b + OFS_SET)) begin
      r = cur | wv;
    end else if (o == 7'(b + OFS_CLR)) begin
      r = cur & ~wv;
    end
    return r;
  endfunction

  // ==========================================================
  // AXI4-Lite write path
  assign wr_go = !aw_rdy_r && !w_rdy_r && !bvalid_r;
  assign wr_hit = mapped(waddr_r);
  assign wo = waddr_r[6:0];
  assign wco = {1'b0, waddr_r[5:0]};
  assign wp = waddr_r[9:7];
  assign wc = waddr_r[9:6];
  assign pwr = wr_go && wr_hit && waddr_r[AW-1:AW-2] == REGION_PORT;
  assign cwr = wr_go && wr_hit && waddr_r[AW-1:AW-2] == REGION_CHAN;
  assign wv = wdata_r & wmask_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_rdy_r <= 1'b1;
      waddr_r <= '0;
    end else if (i_awvalid && aw_rdy_r) begin
      aw_rdy_r <= 1'b0;
      waddr_r <= i_awaddr;
    end else if (bvalid_r && i_bready) begin
      aw_rdy_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      w_rdy_r <= 1'b1;
      wdata_r <= RST_WORD;
      wmask_r <= RST_WORD;
    end else if (i_wvalid && w_rdy_r) begin
      w_rdy_r <= 1'b0;
      wdata_r <= i_wdata;
      for (int b = 0; b < 4; b++) begin
        wmask_r[8*b +: 8] <= {8{i_wstrb[b]}};
      end
    end else if (bvalid_r && i_bready) begin
      w_rdy_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign ar_go = i_arvalid && ar_rdy_r;
  assign ro = i_araddr[6:0];
  assign rco = {1'b0, i_araddr[5:0]};
  assign rp = i_araddr[9:7];
  assign rc = i_araddr[9:6];

  // Registers stay readable whatever the mask holds
  always_comb begin
    rd_v = RST_WORD;
    if (mapped(i_araddr) && i_araddr[AW-1:AW-2] == REGION_PORT) begin
      if (in3(ro, OFS_DATA)) rd_v = data_r[32*rp +: 32];
      else if (in3(ro, OFS_DIR)) rd_v = dir_r[32*rp +: 32];
      else if (in3(ro, OFS_INEN)) rd_v = inen_r[32*rp +: 32];
      else if (in3(ro, OFS_IMASK)) rd_v = imask_r[32*rp +: 32];
      else if (in3(ro, OFS_SENS)) rd_v = sens_r[32*rp +: 32];
      else if (in3(ro, OFS_BOTH)) rd_v = both_r[32*rp +: 32];
      else if (ro == OFS_INPUT) rd_v = sync2_r[32*rp +: 32];
      else if (ro == OFS_ISTAT) rd_v = istat_r[32*rp +: 32];
      else rd_v = mux_r[128*rp + 32*ro[3:2] +: 32];
    end else if (mapped(i_araddr)) begin
      if (in3(rco, OFS_C_MASK)) rd_v = cmask_r[32*rc +: 32];
      else if (in3(rco, OFS_C_EDGE)) rd_v = cedge_r[32*rc +: 32];
      else if (in3(rco, OFS_C_INV)) rd_v = cinv_r[32*rc +: 32];
      else if (rco == OFS_C_ASSIGN) rd_v = cassign_r[32*rc +: 32];
      else if (rco == OFS_C_REQ) rd_v = clatch[32*rc +: 32] & cmask_r[32*rc +: 32];
      else if (rco == OFS_C_LATCH) rd_v = clatch[32*rc +: 32];
      else rd_v = cpins[32*rc +: 32];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= RST_WORD;
      rresp_r <= RESP_OKAY;
    end else if (ar_go) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_v;
      rresp_r <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
      ar_rdy_r <= 1'b1;
    end
  end

  // ==========================================================
  // Port control words
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_r <= '0;
      dir_r <= '0;
      inen_r <= '0;
      imask_r <= '0;
      sens_r <= '0;
      both_r <= '0;
      mux_r <= '0;
    end else if (pwr) begin
      data_r[32*wp +: 32] <= upd3(data_r[32*wp +: 32], wo, OFS_DATA);
      dir_r[32*wp +: 32] <= upd3(dir_r[32*wp +: 32], wo, OFS_DIR);
      inen_r[32*wp +: 32] <= upd3(inen_r[32*wp +: 32], wo, OFS_INEN);
      imask_r[32*wp +: 32] <= upd3(imask_r[32*wp +: 32], wo, OFS_IMASK);
      sens_r[32*wp +: 32] <= upd3(sens_r[32*wp +: 32], wo, OFS_SENS);
      both_r[32*wp +: 32] <= upd3(both_r[32*wp +: 32], wo, OFS_BOTH);
      if (wo >= OFS_MUX) begin
        mux_r[128*wp + 32*wo[3:2] +: 32] <= (mux_r[128*wp + 32*wo[3:2] +: 32] & ~wmask_r) | wv;
      end
    end
  end

  // ==========================================================
  // Channel control words
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmask_r <= '0;
      cedge_r <= '0;
      cinv_r <= '0;
      cassign_r <= '0;
    end else if (cwr) begin
      cmask_r[32*wc +: 32] <= upd3(cmask_r[32*wc +: 32], wco, OFS_C_MASK);
      cedge_r[32*wc +: 32] <= upd3(cedge_r[32*wc +: 32], wco, OFS_C_EDGE);
      cinv_r[32*wc +: 32] <= upd3(cinv_r[32*wc +: 32], wco, OFS_C_INV);
      if (wco == OFS_C_ASSIGN) begin
        cassign_r[32*wc +: 32] <= (cassign_r[32*wc +: 32] & ~wmask_r) | wv;
      end
    end
  end

  // Ones written to the request or latch word clear pending edges
  always_comb begin
    cclr = '0;
    if (cwr && (wco == OFS_C_REQ || wco == OFS_C_LATCH)) begin
      cclr[32*wc +: 32] = wv;
    end
  end

  // ==========================================================
  // Pad synchroniser and GPIO interrupt status
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_pad_in;
      sync2_r <= sync1_r;
    end
  end

  // Output pins take their own data, so software can trigger them
  assign gval = (dir_r & data_r) | (~dir_r & sync2_r);
  assign gev = (sens_r & ((gval & ~gprev_r) | (both_r & ~gval & gprev_r))) | (~sens_r & gval);

  always_comb begin
    rdclr = '0;
    if (ar_go && mapped(i_araddr) && i_araddr[AW-1:AW-2] == REGION_PORT && ro == OFS_ISTAT) begin
      rdclr[32*rp +: 32] = '1;
    end
  end

  // Read-clear loses against a same-cycle event
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gprev_r <= '0;
      istat_r <= '0;
    end else begin
      gprev_r <= gval;
      istat_r <= (istat_r & ~rdclr) | gev;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  // ==========================================================
  // Pin multiplexer and receive path
  for (genvar i = 0; i < NP; i++) begin : g_pin
    logic [SEL_W-1:0] sel;
    logic gpio;
    assign sel = mux_r[MUX_FW*i +: SEL_W];
    // Codes above the last peripheral fall back to GPIO
    assign gpio = (sel == '0) || (int'(sel) > N_FUNC);
    assign out_v[i] = gpio ? data_r[i] : i_func_out[SEL_W'(sel - 3'h1)][i];
    assign oe_v[i] = gpio ? dir_r[i] : i_func_oe[SEL_W'(sel - 3'h1)][i];
    assign rx_v[i] = inen_r[i] & (oe_v[i] ? out_v[i] : sync2_r[i]);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pad_out_r <= '0;
      pad_oe_n_r <= '1;
      func_in_r <= '0;
    end else begin
      pad_out_r <= out_v;
      pad_oe_n_r <= ~oe_v;
      func_in_r <= rx_v;
    end
  end

  // ==========================================================
  // Pin-interrupt channels
  for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
    chan_cfg_s cfg;
    for (genvar s = 0; s < PORT_W / HALF_W; s++) begin : g_slot
      wire [HSEL_W-1:0] hs = cassign_r[32*c + 8*s +: HSEL_W];
      // Raw pad level, not gated by direction or input enable
      assign cpins[32*c + 8*s +: 8] = (int'(hs) < NH) ? sync2_r[8*hs +: 8] : '0;
    end
    assign cfg = '{mask: cmask_r[32*c +: 32], edge_en: cedge_r[32*c +: 32],
                   inv: cinv_r[32*c +: 32]};
    pin_irq_channel u_chan (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_pins(cpins[32*c +: 32]),
      .i_cfg(cfg),
      .i_clr(cclr[32*c +: 32]),
      .o_latch(clatch[32*c +: 32]),
      .o_irq(o_pin_irq[c])
    );
  end

  assign o_awready = aw_rdy_r;
  assign o_wready = w_rdy_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = ar_rdy_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_pad_out = pad_out_r;
  assign o_pad_oe_n = pad_oe_n_r;
  assign o_func_in = func_in_r;
  assign o_irq = irq_r;

  // ==========================================================
  // Checks
  AST_WR_SLVERR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (wr_go && !wr_hit) |=> (o_bvalid && o_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  AST_B_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_bvalid && !i_bready) |=> (o_bvalid && !o_awready && !o_wready))
    else $error("write response dropped early");
  AST_R_ANSWER: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ar_go |=> (o_rvalid && !o_arready))
    else $error("read not answered next cycle");
  AST_DATA_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (pwr && wp == 3'h0 && wo == 7'(OFS_DATA + OFS_SET) && wmask_r == 32'hFFFF_FFFF)
    |=> data_r[31:0] == ($past(data_r[31:0]) | $past(wdata_r)))
    else $error("data set alias wrong");
  AST_DATA_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (pwr && wp == 3'h0 && wo == 7'(OFS_DATA + OFS_CLR) && wmask_r == 32'hFFFF_FFFF)
    |=> data_r[31:0] == ($past(data_r[31:0]) & ~$past(wdata_r)))
    else $error("data clear alias wrong");
  AST_DIR_DRIVE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (mux_r[SEL_W-1:0] == '0 && dir_r[0]) |=> !o_pad_oe_n[0])
    else $error("output pin not driven");
  AST_LOOPBACK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (inen_r[1] && oe_v[1]) |=> o_func_in[1] == $past(out_v[1]))
    else $error("loopback path broken");
  AST_ISTAT_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    gev[0] |=> istat_r[0])
    else $error("event lost");
  AST_ISTAT_RDCLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (rdclr[0] && !gev[0]) |=> !istat_r[0])
    else $error("status not cleared by read");
  AST_IRQ_OUT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ((istat_r & imask_r) != '0) |=> o_irq)
    else $error("unmasked status gives no interrupt");
endmodule // gpio_pin_irq_port
`default_nettype wire

// >>> tb/pad_func_model.sv
// Far side of the port: pads with their external levels, and five peripherals
// Assumes the bench sets the external level of every pin that no one drives
`timescale 1ns/100ps
`default_nettype none
module pad_func_model #(
  parameter int NP = 64
) (
  input wire logic [NP-1:0] i_pad_out,
  input wire logic [NP-1:0] i_pad_oe_n,
  input wire logic [NP-1:0] i_ext,
  output logic [NP-1:0] o_pad_in,
  output logic [gpio_pin_irq_pkg::N_FUNC-1:0][NP-1:0] o_func_out,
  output logic [gpio_pin_irq_pkg::N_FUNC-1:0][NP-1:0] o_func_oe
);
  import gpio_pin_irq_pkg::*;
  // ==========================================================
  // Pad: a driven pin shows its own output, else the outside level
  assign o_pad_in = (~i_pad_oe_n & i_pad_out) | (i_pad_oe_n & i_ext);
  // ==========================================================
  // Peripherals: odd functions drive ones, even ones zeros, always enabled
  always_comb begin
    for (int k = 0; k < N_FUNC; k++) begin
      o_func_out[k] = {NP{k[0]}};
      o_func_oe[k] = {NP{1'b1}};
    end
  end
endmodule // pad_func_model
`default_nettype wire

// >>> tb/tb_gpio_pin_irq_port.sv
// Self-checking bench of the GPIO port block with pin-interrupt channels
// Assumes the design package is compiled first; NPORT stays at two
`timescale 1ns/100ps
`default_nettype none
module tb_gpio_pin_irq_port;
  import gpio_pin_irq_pkg::*;
  localparam int NP = 64;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] rd;
    logic [1:0] rs;
  } row_s;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] pin_irq;
  logic [NP-1:0] ext = '0, pad_in, pad_out, oe_n, func_in;
  logic [N_FUNC-1:0][NP-1:0] fout, foe;
  int miscompares = 0, tests_run = 0, cycles = 0;
  row_s rows [10] = '{
    '{12'h000, 32'h0000_00f0, 12'h000, 32'h0000_00f0, 2'h0},
    '{12'h004, 32'h0000_000f, 12'h000, 32'h0000_00ff, 2'h0},
    '{12'h008, 32'h0000_0030, 12'h000, 32'h0000_00cf, 2'h0},
    '{12'h00c, 32'h0000_00ff, 12'h00c, 32'h0000_00ff, 2'h0},
    '{12'h010, 32'h0000_0100, 12'h00c, 32'h0000_01ff, 2'h0},
    '{12'h014, 32'h0000_0001, 12'h00c, 32'h0000_01fe, 2'h0},
    '{12'h400, 32'hffff_ffff, 12'h400, 32'hffff_ffff, 2'h0},
    '{12'h40c, 32'h0000_00ff, 12'h40c, 32'h0000_00ff, 2'h0},
    // Upper bytes pick a half port past the last one, so they stay quiet
    '{12'h424, 32'h0f0f_0f00, 12'h424, 32'h0f0f_0f00, 2'h0},
    '{12'hffc, 32'h1234_5678, 12'hffc, 32'h0000_0000, 2'h2}};
  always #5 clk = ~clk;
  // ==========================================================
  // Design and far side
  gpio_pin_irq_port #(.NPORT(2)) gpio_pin_irq_port_inst (.i_clk(clk), .i_resetn(resetn),
    .i_awvalid(awv), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe_n(oe_n),
    .i_func_out(fout), .i_func_oe(foe), .o_func_in(func_in), .o_irq(irq),
    .o_pin_irq(pin_irq));
  pad_func_model #(.NP(NP)) pad_func_model_inst (.i_pad_out(pad_out), .i_pad_oe_n(oe_n),
    .i_ext(ext), .o_pad_in(pad_in), .o_func_out(fout), .o_func_oe(foe));
  // ==========================================================
  // Tasks
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address and data offered together; each dropped when its own ready is seen
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= v;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge clk);
    arv <= 1'b1;
    rready <= 1'b1;
    araddr <= a;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // ==========================================================
  // Watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    waitc(5);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      axw(rows[i].wa, rows[i].wd);
      chk(rs, rows[i].rs);
      axr(rows[i].ra);
      chk({d, rs}, {rows[i].rd, rows[i].rs});
    end
    waitc(2);
    chk(pad_out[8:0] & 9'h1fe, 9'h0ce);
    chk(oe_n[8:0], 9'h001);
    axw(12'h050, 32'h0054_3210);
    waitc(2);
    chk({pad_out[5:1], oe_n[5:1]}, 10'h140);
    axw(12'h050, 32'h0000_0000);
    axw(12'h018, 32'h0000_0003);
    waitc(4);
    chk(func_in[1:0], 2'h2);
    axw(12'h014, 32'h0000_00ff);
    waitc(6);
    axw(12'h42c, 32'hffff_ffff);
    waitc(2);
    chk(pin_irq, 6'h00);
    ext[0] <= 1'b1;
    ext[3] <= 1'b1;
    waitc(6);
    chk(pin_irq, 6'h01);
    ext[0] <= 1'b0;
    ext[3] <= 1'b0;
    waitc(6);
    axr(12'h42c);
    chk(d, 32'h0000_0009);
    axw(12'h42c, 32'h0000_0009);
    waitc(2);
    chk(pin_irq, 6'h00);
    axr(12'h428);
    chk(d, 32'h0000_0000);
    // Pin four: level sensed, active low, pin held low outside
    axw(12'h414, 32'h0000_0010);
    axw(12'h41c, 32'h0000_0010);
    waitc(6);
    chk(pin_irq, 6'h01);
    axw(12'h408, 32'hffff_ffff);
    waitc(2);
    chk(pin_irq, 6'h00);
    axr(12'h42c);
    chk(d, 32'h0000_0010);
    // Port status: a software-driven output pin raises the line once unmasked
    axr(12'h04c);
    axw(12'h004, 32'h0000_0100);
    waitc(4);
    chk(irq, 1'b0);
    axw(12'h024, 32'h0000_0100);
    waitc(3);
    chk(irq, 1'b1);
    axw(12'h008, 32'h0000_0100);
    waitc(3);
    axr(12'h04c);
    chk(d, 32'h0000_0100);
    axr(12'h04c);
    chk(d, 32'h0000_0000);
    waitc(2);
    chk(irq, 1'b0);
    // Pin three: port edge sensing, both edges then rising only; channel five level
    axw(12'h034, 32'h0000_0008);
    axw(12'h040, 32'h0000_0008);
    axw(12'h540, 32'h0000_0008);
    ext[3] <= 1'b1;
    waitc(4);
    axr(12'h04c);
    chk(d, 32'h0000_0008);
    chk(pin_irq, 6'h20);
    ext[3] <= 1'b0;
    waitc(4);
    axr(12'h04c);
    chk(d, 32'h0000_0008);
    chk(pin_irq, 6'h00);
    axw(12'h044, 32'h0000_0008);
    ext[3] <= 1'b1;
    waitc(4);
    axr(12'h04c);
    chk(d, 32'h0000_0008);
    ext[3] <= 1'b0;
    waitc(4);
    axr(12'h04c);
    chk(d, 32'h0000_0000);
    // Reset in mid-run
    @(posedge clk);
    resetn <= 1'b0;
    waitc(2);
    chk(oe_n, {NP{1'b1}});
    chk({irq, pin_irq}, 7'h00);
    resetn <= 1'b1;
    axr(12'h000);
    chk(d, 32'h0000_0000);
    complete_run();
  end
endmodule // tb_gpio_pin_irq_port
`default_nettype wire
